// file: reset_park_pkg.sv
package reset_park_pkg;

  // ************************************************************
  // widths and timing
  // ************************************************************
  localparam int unsigned TP_WIDTH        = 8;
  localparam int unsigned SYS_CLK_MHZ     = 200;
  localparam int unsigned STRAP_DELAY_NS  = 1500;
  // least time, so round up to whole cycles
  localparam int unsigned STRAP_DELAY_CYC =
    (STRAP_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned STRAP_CNT_W     = $clog2(STRAP_DELAY_CYC + 1);

  // ************************************************************
  // pin levels and reset values
  // ************************************************************
  localparam logic [TP_WIDTH-1:0] TP_ALL_LOW = 8'h00;
  localparam logic [TP_WIDTH-1:0] TP_OE_OFF  = 8'hFF;
  localparam logic [TP_WIDTH-1:0] TP_OE_ON   = 8'h00;
  localparam logic [TP_WIDTH-1:0] TP_SYNC_RST = 8'h00;
  localparam logic                POR_SYNC_RST  = 1'b0;
  localparam logic                PARK_SYNC_RST = 1'b1;
  localparam logic                MFG_SYNC_RST  = 1'b0;
  localparam logic                TAR_SYNC_RST  = 1'b0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_HELD   = 2'h0,
    ST_WAIT   = 2'h1,
    ST_SAMPLE = 2'h3,
    ST_RUN    = 2'h2
  } seq_state_t;

  typedef struct packed {
    logic                test_mode;
    logic [TP_WIDTH-1:0] select;
  } strap_t;

  typedef struct packed {
    logic request;
    logic start;
  } park_t;

  typedef struct packed {
    logic mfg_test_active;
    logic test_access_fault;
  } test_pin_status_t;

  localparam strap_t           STRAP_RST  = '{test_mode: 1'b0, select: 8'h00};
  localparam park_t            PARK_RST   = '{request: 1'b0, start: 1'b0};
  localparam test_pin_status_t TSTAT_RST  = '{mfg_test_active: 1'b0,
                                              test_access_fault: 1'b0};

endpackage

// file: pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
  parameter int unsigned     WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule

// file: reset_park_test_strap_ctrl.sv
`timescale 1ns/1ps

// Notes on behaviour
// - rising power-on reset starts self-configuration
// - no output active while reset low
// - test points float while reset low
// - sample test points 1.5us after release
// - then drive test points as outputs
// - any high sample selects test mode
// - low fast-park input requests quick park
module reset_park_test_strap_ctrl #(
  parameter int unsigned TP_W = reset_park_pkg::TP_WIDTH
) (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_power_on_reset_n,
  input  wire logic                       i_fast_park_request_n,
  input  wire logic                       i_manufacturing_test_enable,
  input  wire logic                       i_test_access_reset_n,
  input  wire logic [TP_W-1:0]            i_test_point_pins,
  input  wire logic [TP_W-1:0]            i_test_out_data,
  output logic                            o_config_start,
  output logic                            o_config_busy,
  output logic                            o_run,
  output reset_park_pkg::strap_t          o_strap,
  output reset_park_pkg::park_t           o_park,
  output reset_park_pkg::test_pin_status_t o_test_status,
  output logic [TP_W-1:0]                 o_test_point_pins,
  output logic [TP_W-1:0]                 o_test_point_oe_n
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic            por_ok;
  logic            park_n_sync;
  logic            mfg_sync;
  logic            tar_n_sync;
  logic [TP_W-1:0] tp_sync;

  pin_sync #(
    .WIDTH   (1),
    .RST_VAL (reset_park_pkg::POR_SYNC_RST)
  ) u_por_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_power_on_reset_n),
    .o_sync    (por_ok)
  );

  pin_sync #(
    .WIDTH   (1),
    .RST_VAL (reset_park_pkg::PARK_SYNC_RST)
  ) u_park_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_fast_park_request_n),
    .o_sync    (park_n_sync)
  );

  pin_sync #(
    .WIDTH   (1),
    .RST_VAL (reset_park_pkg::MFG_SYNC_RST)
  ) u_mfg_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_manufacturing_test_enable),
    .o_sync    (mfg_sync)
  );

  pin_sync #(
    .WIDTH   (1),
    .RST_VAL (reset_park_pkg::TAR_SYNC_RST)
  ) u_tar_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_test_access_reset_n),
    .o_sync    (tar_n_sync)
  );

  pin_sync #(
    .WIDTH   (TP_W),
    .RST_VAL (reset_park_pkg::TP_SYNC_RST)
  ) u_tp_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_test_point_pins),
    .o_sync    (tp_sync)
  );

  // ************************************************************
  // sequence state
  // ************************************************************
  reset_park_pkg::seq_state_t                    state_reg;
  reset_park_pkg::seq_state_t                    state_next;
  logic [reset_park_pkg::STRAP_CNT_W-1:0]        cnt_reg;
  logic [reset_park_pkg::STRAP_CNT_W-1:0]        cnt_next;

  localparam logic [reset_park_pkg::STRAP_CNT_W-1:0] CNT_LAST =
    reset_park_pkg::STRAP_CNT_W'(reset_park_pkg::STRAP_DELAY_CYC - 1);
  localparam logic [reset_park_pkg::STRAP_CNT_W-1:0] CNT_ZERO =
    reset_park_pkg::STRAP_CNT_W'(0);
  localparam logic [reset_park_pkg::STRAP_CNT_W-1:0] CNT_ONE =
    reset_park_pkg::STRAP_CNT_W'(1);

  wire in_held   = (state_reg == reset_park_pkg::ST_HELD);
  wire in_wait   = (state_reg == reset_park_pkg::ST_WAIT);
  wire in_sample = (state_reg == reset_park_pkg::ST_SAMPLE);
  wire in_run    = (state_reg == reset_park_pkg::ST_RUN);
  wire cnt_done  = (cnt_reg == CNT_LAST);

  // a drop of the reset pin at any point restarts the whole sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      reset_park_pkg::ST_HELD: begin
        if (por_ok) begin
          state_next = reset_park_pkg::ST_WAIT;
        end
      end
      reset_park_pkg::ST_WAIT: begin
        if (!por_ok) begin
          state_next = reset_park_pkg::ST_HELD;
        end else if (cnt_done) begin
          state_next = reset_park_pkg::ST_SAMPLE;
        end
      end
      reset_park_pkg::ST_SAMPLE: begin
        if (!por_ok) begin
          state_next = reset_park_pkg::ST_HELD;
        end else begin
          state_next = reset_park_pkg::ST_RUN;
        end
      end
      reset_park_pkg::ST_RUN: begin
        if (!por_ok) begin
          state_next = reset_park_pkg::ST_HELD;
        end
      end
      default: begin
        state_next = reset_park_pkg::ST_HELD;
      end
    endcase
  end

  assign cnt_next = (in_wait && por_ok && !cnt_done) ? cnt_reg + CNT_ONE : CNT_ZERO;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= reset_park_pkg::ST_HELD;
      cnt_reg   <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // ************************************************************
  // strap capture
  // ************************************************************
  reset_park_pkg::strap_t strap_reg;
  reset_park_pkg::strap_t strap_next;

  // captured once per release; cleared while reset is low
  always_comb begin
    strap_next = strap_reg;
    if (!por_ok) begin
      strap_next = reset_park_pkg::STRAP_RST;
    end else if (in_sample) begin
      strap_next.select    = tp_sync;
      strap_next.test_mode = (tp_sync != reset_park_pkg::TP_ALL_LOW);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_reg <= reset_park_pkg::STRAP_RST;
    end else begin
      strap_reg <= strap_next;
    end
  end

  // ************************************************************
  // test point drivers
  // ************************************************************
  logic [TP_W-1:0] tp_out_reg;
  logic [TP_W-1:0] tp_oe_n_reg;

  // pins stay released until the strap has been taken
  wire drive_tp = por_ok && (in_sample || in_run);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tp_out_reg  <= reset_park_pkg::TP_ALL_LOW;
      tp_oe_n_reg <= reset_park_pkg::TP_OE_OFF;
    end else begin
      tp_out_reg  <= drive_tp ? i_test_out_data : reset_park_pkg::TP_ALL_LOW;
      tp_oe_n_reg <= drive_tp ? reset_park_pkg::TP_OE_ON
                              : reset_park_pkg::TP_OE_OFF;
    end
  end

  // ************************************************************
  // fast park
  // ************************************************************
  reset_park_pkg::park_t park_reg;
  reset_park_pkg::park_t park_next;

  // park is only meaningful once configured; the partner keeps it rare
  always_comb begin
    park_next.request = por_ok && in_run && !park_n_sync;
    park_next.start   = park_next.request && !park_reg.request;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      park_reg <= reset_park_pkg::PARK_RST;
    end else begin
      park_reg <= park_next;
    end
  end

  // ************************************************************
  // configuration status and test pin checks
  // ************************************************************
  logic                             start_reg;
  logic                             busy_reg;
  logic                             run_reg;
  reset_park_pkg::test_pin_status_t tstat_reg;
  reset_park_pkg::test_pin_status_t tstat_next;

  wire start_next = in_held && por_ok;
  wire busy_next  = por_ok && (in_wait || in_sample || start_next);
  wire run_next   = por_ok && in_run;

  // flags only; startup is not blocked, the partner keeps these low
  assign tstat_next.mfg_test_active   = por_ok && mfg_sync;
  assign tstat_next.test_access_fault = por_ok && tar_n_sync;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_reg <= 1'b0;
      busy_reg  <= 1'b0;
      run_reg   <= 1'b0;
      tstat_reg <= reset_park_pkg::TSTAT_RST;
    end else begin
      start_reg <= start_next;
      busy_reg  <= busy_next;
      run_reg   <= run_next;
      tstat_reg <= tstat_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the reset source must not release early; nothing here guards it
  assign o_config_start    = start_reg;
  assign o_config_busy     = busy_reg;
  assign o_run             = run_reg;
  assign o_strap           = strap_reg;
  assign o_park            = park_reg;
  assign o_test_status     = tstat_reg;
  assign o_test_point_pins = tp_out_reg;
  assign o_test_point_oe_n = tp_oe_n_reg;

endmodule

// file: reset_park_chk.sv
`timescale 1ns/1ps

// ********
// checker
// ********
module reset_park_chk #(
  parameter int unsigned TP_W = 8
) (
  input wire logic                             i_sys_clk,
  input wire logic                             i_rst_n,
  input wire logic                             i_power_on_reset_n,
  input wire logic                             i_fast_park_request_n,
  input wire logic                             o_config_start,
  input wire logic                             o_config_busy,
  input wire logic                             o_run,
  input wire reset_park_pkg::strap_t           o_strap,
  input wire reset_park_pkg::park_t            o_park,
  input wire reset_park_pkg::test_pin_status_t o_test_status,
  input wire logic [TP_W-1:0]                  o_test_point_pins,
  input wire logic [TP_W-1:0]                  o_test_point_oe_n
);
  logic [9:0] age_reg;
  logic [9:0] age_next;
  // wait span, then one sample cycle before run is registered
  localparam logic [9:0] RUN_AGE = 10'(reset_park_pkg::STRAP_DELAY_CYC + 1);

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // saturates so a long run never wraps back into the window
  assign age_next = o_config_start ? 10'h000 :
                    (age_reg == 10'h3FF) ? age_reg : age_reg + 10'h001;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) age_reg <= 10'h000;
    else age_reg <= age_next;
  end

  a_start_on_rise: assert property (
    $rose(i_power_on_reset_n) ##1 i_power_on_reset_n [*2] |=> o_config_start)
    else $error("config start missing after reset release");
  a_start_one_cycle: assert property (
    o_config_start |=> !o_config_start) else $error("config start too long");
  a_idle_in_reset: assert property (
    (!i_power_on_reset_n) [*3] |=> !o_config_start && !o_config_busy && !o_run
      && o_park == 2'h0 && o_strap == 9'h000 && o_test_status == 2'h0)
    else $error("output active while reset low");
  a_float_in_reset: assert property (
    (!i_power_on_reset_n) [*3] |=> o_test_point_oe_n == 8'hFF && o_test_point_pins == 8'h00)
    else $error("test points driven in reset");
  a_strap_span: assert property (
    $rose(o_run) |-> age_reg == RUN_AGE) else $error("strap delay wrong");
  a_drive_after: assert property (
    o_run |-> o_test_point_oe_n == 8'h00) else $error("test points not driven");
  a_mode_from: assert property (
    o_run |-> o_strap.test_mode == (|o_strap.select)) else $error("test mode wrong");
  a_park_answer: assert property (
    o_run && $fell(i_fast_park_request_n) ##1 (o_run && !i_fast_park_request_n) [*2]
      |=> o_park.request && o_park.start) else $error("park not answered");
  a_park_sync: assert property (
    o_run && !o_park.request && $fell(i_fast_park_request_n) |-> (!o_park.request) [*3])
    else $error("park acted before sync");
endmodule

bind reset_park_test_strap_ctrl reset_park_chk #(.TP_W(TP_W)) u_chk (
  .i_sys_clk, .i_rst_n, .i_power_on_reset_n, .i_fast_park_request_n,
  .o_config_start, .o_config_busy, .o_run, .o_strap, .o_park, .o_test_status,
  .o_test_point_pins, .o_test_point_oe_n);

// file: pmic_model.sv
`timescale 1ns/1ps

// ********
// power management side
// ********
module pmic_model (
  input  wire logic i_sys_clk,
  output logic      o_power_on_reset_n,
  output logic      o_fast_park_request_n
);
  initial begin
    o_power_on_reset_n = 1'b0;
    o_fast_park_request_n = 1'b1;
  end

  // clock already runs here, so release only after a settle span
  task automatic power_cycle(input int low_cyc);
    @(posedge i_sys_clk) #1;
    o_power_on_reset_n = 1'b0;
    repeat (low_cyc) @(posedge i_sys_clk);
    #1 o_power_on_reset_n = 1'b1;
  endtask

  // only issued where a normal park cannot finish
  task automatic fast_park(input int low_cyc);
    @(posedge i_sys_clk) #1;
    o_fast_park_request_n = 1'b0;
    repeat (low_cyc) @(posedge i_sys_clk);
    #1 o_fast_park_request_n = 1'b1;
  endtask
endmodule

// file: test_reset_park_test_strap_ctrl.sv
`timescale 1ns/1ps
`define CHK(nm, exp, act) begin total_checks++; if ((act) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, exp, act); end end

module test_reset_park_test_strap_ctrl;
  localparam int unsigned W = reset_park_pkg::TP_WIDTH;
  logic                             sys_clk;
  logic                             rst_n;
  logic                             mfg_en;
  logic                             tar_n;
  logic [W-1:0]                     pull;
  logic [W-1:0]                     out_data;
  logic [W-1:0]                     tp_out;
  logic [W-1:0]                     tp_oe_n;
  logic [W-1:0]                     tp_wire;
  wire                              por_n;
  wire                              park_n;
  logic                             start;
  logic                             busy;
  logic                             run;
  reset_park_pkg::strap_t           strap;
  reset_park_pkg::park_t            park;
  reset_park_pkg::test_pin_status_t tstat;
  int                               miscompares = 0;
  int                               total_checks = 0;

  // released pins fall to the pull level, zero being the weak pulldown
  assign tp_wire = (~tp_oe_n & tp_out) | (tp_oe_n & pull);

  pmic_model pm (.i_sys_clk(sys_clk), .o_power_on_reset_n(por_n), .o_fast_park_request_n(park_n));

  reset_park_test_strap_ctrl dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_power_on_reset_n(por_n),
    .i_fast_park_request_n(park_n), .i_manufacturing_test_enable(mfg_en),
    .i_test_access_reset_n(tar_n), .i_test_point_pins(tp_wire), .i_test_out_data(out_data),
    .o_config_start(start), .o_config_busy(busy), .o_run(run), .o_strap(strap),
    .o_park(park), .o_test_status(tstat), .o_test_point_pins(tp_out),
    .o_test_point_oe_n(tp_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_boot(input logic [W-1:0] p);
    int n;
    n = 0;
    pull = p;
    pm.power_cycle(10);
    `CHK("oe_n held", 8'hFF, tp_oe_n)
    `CHK("run held", 1'b0, run)
    while (start !== 1'b1 && n < 10) begin @(posedge sys_clk); #1; n++; end
    `CHK("start lag", 3, n)
    n = 0;
    while (run !== 1'b1 && n < 400) begin @(posedge sys_clk); #1; n++; end
    `CHK("strap span", reset_park_pkg::STRAP_DELAY_CYC + 2, n)
    `CHK("busy done", 1'b0, busy)
    `CHK("select", p, strap.select)
    `CHK("mode", |p, strap.test_mode)
    `CHK("oe_n on", 8'h00, tp_oe_n)
    pull = ~p;
    out_data = p ^ 8'h5A;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("tp drive", p ^ 8'h5A, tp_out)
    `CHK("strap kept", p, strap.select)
  endtask

  task automatic t_park();
    int n;
    n = 0;
    fork
      pm.fast_park(20);
      begin
        @(negedge park_n);
        while (park.request !== 1'b1 && n < 10) begin @(posedge sys_clk); #1; n++; end
        `CHK("park lag", 3, n)
        `CHK("park start", 1'b1, park.start)
        @(posedge sys_clk) #1;
        `CHK("park pulse", 1'b0, park.start)
      end
    join
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("park off", 1'b0, park.request)
  endtask

  task automatic t_restart();
    pm.power_cycle(10);
    repeat (50) @(posedge sys_clk);
    #1;
    `CHK("busy", 1'b1, busy)
    pm.fast_park(6);
    `CHK("park ignored", 1'b0, park.request)
    pm.power_cycle(6);
    `CHK("busy cleared", 1'b0, busy)
    t_boot(8'h00);
  endtask

  task automatic t_flags();
    tar_n = 1'b1;
    mfg_en = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("tar flag", 1'b1, tstat.test_access_fault)
    `CHK("mfg flag", 1'b1, tstat.mfg_test_active)
    tar_n = 1'b0;
    mfg_en = 1'b0;
    rst_n = 1'b0;
    #1;
    `CHK("oe_n in reset", 8'hFF, tp_oe_n)
    @(posedge sys_clk) #1;
    rst_n = 1'b1;
  endtask

  initial begin
    rst_n = 1'b0;
    mfg_en = 1'b0;
    tar_n = 1'b0;
    pull = 8'h00;
    out_data = 8'h3C;
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_boot(8'h00);
    t_boot(8'h01);
    t_boot(8'h80);
    t_boot(8'hA5);
    t_park();
    t_restart();
    t_flags();
    give_verdict();
  end

  // about 1700 cycles expected; allow ample margin
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule
